// ==== src/afa_flags.sv ====
// Converter flag register: threshold flags, overrun mirrors, summaries.
// Assumes result units clear their own overrun and valid bits on reads.
`timescale 1ns/1ps
module afa_flags (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Register port
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Result unit status
  input wire logic [11:0] chan_overrun_i,
  input wire logic seq_a_global_overrun_i,
  input wire logic seq_b_global_overrun_i,
  input wire logic seq_a_result_valid_i,
  input wire logic seq_b_result_valid_i,
  // Sequencer status
  input wire logic seq_a_mode_i,
  input wire logic seq_b_mode_i,
  input wire logic seq_a_pass_done_i,
  input wire logic seq_b_pass_done_i,
  // Threshold comparators, pulses per channel
  input wire logic [11:0] thr_out_of_range_i,
  input wire logic [11:0] thr_crossing_i,
  // Interrupt enable register contents
  input wire logic seq_a_irq_en_i,
  input wire logic seq_b_irq_en_i,
  input wire logic overrun_irq_en_i,
  input wire logic [11:0] thr_range_en_i,
  input wire logic [11:0] thr_cross_en_i,
  // Interrupt requests
  output logic seq_a_irq_o,
  output logic seq_b_irq_o,
  output logic threshold_irq_o,
  output logic overrun_irq_o
);
  typedef struct packed {
    logic rst_meta;
    logic rst_sync;
    logic [11:0] channel_threshold_event;
    logic [31:0] rdata;
    logic seq_a_irq;
    logic seq_b_irq;
    logic thr_irq;
    logic ovr_irq;
  } afa_st_s;

  afa_st_s st;
  afa_st_s next_st;
  logic [1:0] rst_pipe;
  logic rst_n;
  logic seq_a_irq_flag;
  logic seq_b_irq_flag;
  logic threshold_summary_flag;
  logic overrun_summary_flag;
  logic [31:0] flag_word;

  function automatic logic hit(input logic [31:0] a);
    hit = (a == afa_pkg::FLAG_OFFSET);
  endfunction

  function automatic logic w1c(input logic [31:0] a, input logic [31:0] d,
                               input int bit_pos);
    w1c = hit(a) && d[bit_pos];
  endfunction

  // Reset release through two flops
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  afa_seq_flag u_seq_a (
    .clk_i(mclk_i),
    .rst_n_i(rst_n),
    .mode_i(seq_a_mode_i),
    .result_valid_i(seq_a_result_valid_i),
    .pass_done_i(seq_a_pass_done_i),
    .clear_w1c_i(wr_i && w1c(addr_i, wdata_i, afa_pkg::SEQA_FLAG_BIT)),
    .flag_o(seq_a_irq_flag)
  );

  afa_seq_flag u_seq_b (
    .clk_i(mclk_i),
    .rst_n_i(rst_n),
    .mode_i(seq_b_mode_i),
    .result_valid_i(seq_b_result_valid_i),
    .pass_done_i(seq_b_pass_done_i),
    .clear_w1c_i(wr_i && w1c(addr_i, wdata_i, afa_pkg::SEQB_FLAG_BIT)),
    .flag_o(seq_b_irq_flag)
  );

  // Summary of threshold flags
  assign threshold_summary_flag = |st.channel_threshold_event;

  // Overrun summary; global overrun only in per-conversion mode
  assign overrun_summary_flag = (|chan_overrun_i)
    | (seq_a_global_overrun_i && seq_a_mode_i == afa_pkg::MODE_PER_CONV)
    | (seq_b_global_overrun_i && seq_b_mode_i == afa_pkg::MODE_PER_CONV);

  always_comb begin
    flag_word = afa_pkg::RD_RESET;
    flag_word[afa_pkg::THR_LSB +: 12] = st.channel_threshold_event;
    flag_word[afa_pkg::CH_OVR_LSB +: 12] = chan_overrun_i;
    flag_word[afa_pkg::SEQ_A_GLOBAL_OVERRUN_MIRROR_BIT] = seq_a_global_overrun_i;
    flag_word[afa_pkg::SEQ_B_GLOBAL_OVERRUN_MIRROR_BIT] = seq_b_global_overrun_i;
    flag_word[afa_pkg::RSVD_LSB +: 2] = 2'h0;
    flag_word[afa_pkg::SEQA_FLAG_BIT] = seq_a_irq_flag;
    flag_word[afa_pkg::SEQB_FLAG_BIT] = seq_b_irq_flag;
    flag_word[afa_pkg::THR_SUM_BIT] = threshold_summary_flag;
    flag_word[afa_pkg::OVR_SUM_BIT] = overrun_summary_flag;
  end

  always_comb begin
    next_st = st;
    next_st.rst_meta = 1'b0;
    next_st.rst_sync = 1'b0;
    for (int i = 0; i < afa_pkg::NUM_CHAN; i++) begin
      // Set wins over the clear; writing 0 keeps the flag
      if ((thr_out_of_range_i[i] && thr_range_en_i[i]) ||
          (thr_crossing_i[i] && thr_cross_en_i[i])) begin
        next_st.channel_threshold_event[i] = 1'b1;
      end else if (wr_i && w1c(addr_i, wdata_i, afa_pkg::THR_LSB + i)) begin
        next_st.channel_threshold_event[i] = 1'b0;
      end
    end
    // Read data stand only in the cycle after the strobe
    next_st.rdata = afa_pkg::RD_RESET;
    if (rd_i && hit(addr_i)) begin
      next_st.rdata = flag_word;
    end
    next_st.seq_a_irq = seq_a_irq_flag && seq_a_irq_en_i;
    next_st.seq_b_irq = seq_b_irq_flag && seq_b_irq_en_i;
    next_st.thr_irq = threshold_summary_flag;
    next_st.ovr_irq = overrun_summary_flag && overrun_irq_en_i;
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o = st.rdata;
  assign seq_a_irq_o = st.seq_a_irq;
  assign seq_b_irq_o = st.seq_b_irq;
  assign threshold_irq_o = st.thr_irq;
  assign overrun_irq_o = st.ovr_irq;
endmodule

// ==== src/afa_pkg.sv ====
// Package for the converter flag aggregation block: offsets, fields, resets.
// Assumes a plain address/strobe register port with 32-bit data.
package afa_pkg;
  localparam int NUM_CHAN = 12;
  localparam logic [31:0] FLAG_OFFSET = 32'h4001c068;
  localparam int THR_LSB = 0;
  localparam int CH_OVR_LSB = 12;
  localparam int SEQ_A_GLOBAL_OVERRUN_MIRROR_BIT = 24;
  localparam int SEQ_B_GLOBAL_OVERRUN_MIRROR_BIT = 25;
  localparam int RSVD_LSB = 26;
  localparam int SEQA_FLAG_BIT = 28;
  localparam int SEQB_FLAG_BIT = 29;
  localparam int THR_SUM_BIT = 30;
  localparam int OVR_SUM_BIT = 31;
  localparam logic [11:0] THR_RESET = 12'h000;
  localparam logic [31:0] RD_RESET = 32'h00000000;
  localparam logic MODE_PER_CONV = 1'b0;
  localparam logic MODE_WHOLE_SEQ = 1'b1;
endpackage

// ==== src/afa_seq_flag.sv ====
// One sequence completion flag, selected by the sequence mode bit.
// Assumes synchronous event inputs from the sequencer and result unit.
`timescale 1ns/1ps
module afa_seq_flag (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Sequence status
  input wire logic mode_i,
  input wire logic result_valid_i,
  input wire logic pass_done_i,
  input wire logic clear_w1c_i,
  // Flag out
  output logic flag_o
);
  typedef struct packed {
    logic sticky;
  } afa_sf_s;

  afa_sf_s st;
  afa_sf_s next_st;

  always_comb begin
    next_st = st;
    // Set wins over the software clear
    if (pass_done_i) begin
      next_st.sticky = 1'b1;
    end else if (clear_w1c_i) begin
      next_st.sticky = 1'b0;
    end
    if (mode_i == afa_pkg::MODE_PER_CONV) begin
      next_st.sticky = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Per-conversion: valid bit cleared by its own reader
  assign flag_o = (mode_i == afa_pkg::MODE_PER_CONV) ? result_valid_i
                                                      : st.sticky;
endmodule

// ==== testbench/afa_flags_bench.sv ====
// Self-checking bench for the converter flag register.
// Assumes the checker is bound in; drives every port itself.
`timescale 1ns/1ps
module afa_flags_bench;
  localparam logic [31:0] FA = afa_pkg::FLAG_OFFSET;
  logic mclk_i = 1'b0, arst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic [31:0] addr_i = 32'h0, wdata_i = 32'h0, rdata_o;
  logic [11:0] chan_overrun_i = 12'h0, thr_out_of_range_i = 12'h0;
  logic [11:0] thr_crossing_i = 12'h0, thr_range_en_i = 12'h0;
  logic [11:0] thr_cross_en_i = 12'h0;
  logic seq_a_global_overrun_i = 1'b0, seq_b_global_overrun_i = 1'b0;
  logic seq_a_result_valid_i = 1'b0, seq_b_result_valid_i = 1'b0;
  logic seq_a_mode_i = 1'b0, seq_b_mode_i = 1'b0;
  logic seq_a_pass_done_i = 1'b0, seq_b_pass_done_i = 1'b0;
  logic seq_a_irq_en_i = 1'b0, seq_b_irq_en_i = 1'b0;
  logic overrun_irq_en_i = 1'b0;
  logic seq_a_irq_o, seq_b_irq_o, threshold_irq_o, overrun_irq_o;
  int err_total = 0, total_checks = 0;
  // Status inputs beside the expected flag word bits 31:12
  logic [37:0] rows [5] = '{{18'h00040, 20'h80001},
    {18'h20003, 20'hb0800}, {18'h00033, 20'hb3000},
    {18'h0002c, 20'h01000}, {18'h00014, 20'h02000}};
  afa_flags dut (.*);
  initial begin
    forever #10 mclk_i = ~mclk_i;
  end
  task chk(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task rd_t(input logic [31:0] a, e, input string n);
    @(posedge mclk_i) addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i) rd_i <= 1'b0;
    #1 chk(n, e, rdata_o);
    $display("test %s done", n);
  endtask
  task wr_t(input logic [31:0] a, d);
    @(posedge mclk_i) addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i) wr_i <= 1'b0;
  endtask
  task results;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rd_t(FA, afa_pkg::RD_RESET, "reset");
    overrun_irq_en_i <= 1'b1;
    foreach (rows[i]) begin
      @(posedge mclk_i) {chan_overrun_i, seq_a_global_overrun_i,
        seq_b_global_overrun_i, seq_a_mode_i, seq_b_mode_i,
        seq_a_result_valid_i, seq_b_result_valid_i} <= rows[i][37:20];
      rd_t(FA, {rows[i][19:0], 12'h000}, "row");
      chk("ovr irq", {31'h0, rows[i][19]}, {31'h0, overrun_irq_o});
    end
    wr_t(FA, 32'hf3ffffff);
    rd_t(FA, 32'h02000000, "write mirrors");
    rd_t(FA + 32'h4, 32'h0, "unmapped");
    @(posedge mclk_i) thr_range_en_i <= 12'h008;
    thr_cross_en_i <= 12'h080;
    thr_out_of_range_i <= 12'h028;
    thr_crossing_i <= 12'h0a0;
    {seq_b_global_overrun_i, seq_b_mode_i} <= 2'h0;
    @(posedge mclk_i) thr_out_of_range_i <= 12'h0;
    thr_crossing_i <= 12'h0;
    rd_t(FA, 32'h40000088, "thr set");
    chk("thr irq", 32'h1, {31'h0, threshold_irq_o});
    wr_t(FA, 32'h0);
    rd_t(FA, 32'h40000088, "write zero");
    wr_t(FA, 32'h8);
    rd_t(FA, 32'h40000080, "thr partial");
    wr_t(FA, 32'h80);
    rd_t(FA, 32'h0, "thr clear");
    chk("thr irq off", 32'h0, {31'h0, threshold_irq_o});
    @(posedge mclk_i) {seq_a_mode_i, seq_b_mode_i, seq_a_irq_en_i} <= 3'h7;
    {seq_a_pass_done_i, seq_b_pass_done_i} <= 2'h3;
    @(posedge mclk_i) {seq_a_pass_done_i, seq_b_pass_done_i} <= 2'h0;
    rd_t(FA, 32'h30000000, "pass");
    chk("a irq", 32'h1, {31'h0, seq_a_irq_o});
    chk("b irq", 32'h0, {31'h0, seq_b_irq_o});
    wr_t(FA, 32'h10000000);
    rd_t(FA, 32'h20000000, "clear a");
    wr_t(FA, 32'h20000000);
    rd_t(FA, 32'h0, "clear b");
    results();
  end
endmodule

// ==== testbench/afa_flags_sva.sv ====
// Checker for the flag register read port and the overrun interrupt output.
// Assumes it is bound to afa_flags and sees only its ports.
`timescale 1ns/1ps
module afa_flags_chk (
  // Clock, reset, register port
  input wire logic mclk_i, arst_n_i, rd_i,
  input wire logic [31:0] addr_i, rdata_o,
  // Status inputs
  input wire logic [11:0] chan_overrun_i,
  input wire logic seq_a_global_overrun_i, seq_b_global_overrun_i,
  input wire logic seq_a_result_valid_i, seq_b_result_valid_i,
  input wire logic seq_a_mode_i, seq_b_mode_i, seq_a_pass_done_i,
  // Overrun request
  input wire logic overrun_irq_en_i, overrun_irq_o
);
  wire hit = rd_i && addr_i == afa_pkg::FLAG_OFFSET;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_pass;
    seq_a_mode_i && seq_a_pass_done_i;
  endsequence
  sequence s_rda;
    hit && seq_a_mode_i;
  endsequence
  property p_mir;
    hit |=> rdata_o[23:12] == $past(chan_overrun_i);
  endproperty
  property p_gov;
    hit |=> rdata_o[25:24] ==
      $past({seq_b_global_overrun_i, seq_a_global_overrun_i});
  endproperty
  property p_rsv;
    hit |=> rdata_o[27:26] == 2'h0;
  endproperty
  property p_sqa;
    hit && !seq_a_mode_i |=> rdata_o[28] == $past(seq_a_result_valid_i);
  endproperty
  property p_sqb;
    hit && !seq_b_mode_i |=> rdata_o[29] == $past(seq_b_result_valid_i);
  endproperty
  property p_ovs;
    hit |=> rdata_o[31] == $past(|chan_overrun_i ||
      seq_a_global_overrun_i && !seq_a_mode_i ||
      seq_b_global_overrun_i && !seq_b_mode_i);
  endproperty
  property p_ths;
    hit |=> rdata_o[30] == |rdata_o[11:0];
  endproperty
  property p_sta;
    s_pass ##[1:2] s_rda |=> rdata_o[28];
  endproperty
  property p_ovi;
    !overrun_irq_en_i [*3] |-> !overrun_irq_o;
  endproperty
  a_mir: assert property (p_mir)
    else $error("channel overrun mirror wrong");
  a_gov: assert property (p_gov)
    else $error("global overrun mirror wrong");
  a_rsv: assert property (p_rsv)
    else $error("reserved bits not zero");
  a_sqa: assert property (p_sqa)
    else $error("sequence a flag not valid bit");
  a_sqb: assert property (p_sqb)
    else $error("sequence b flag not valid bit");
  a_ovs: assert property (p_ovs)
    else $error("overrun summary wrong");
  a_ths: assert property (p_ths)
    else $error("threshold summary wrong");
  a_sta: assert property (p_sta)
    else $error("sequence a pass flag missing");
  a_ovi: assert property (p_ovi)
    else $error("overrun request while disabled");
endmodule
bind afa_flags afa_flags_chk u_chk (.*);
